// [core/gcp_pkg.sv]
// gcp_pkg: shared constants for the graphics command poll control block
// assumes a 32-bit apb register bus and a 10 MHz system clock
package gcp_pkg;

    // apb byte offsets
    localparam logic [7:0] GCP_OPCODE_OFF = 8'h00;
    localparam logic [7:0] GCP_STATUS_OFF = 8'h04;
    localparam logic [7:0] GCP_IPTR_OFF = 8'h08;
    localparam logic [7:0] GCP_IMASK_OFF = 8'h0c;
    localparam logic [7:0] GCP_PMASK_OFF = 8'h10;
    localparam logic [7:0] GCP_CTRL_OFF = 8'h14;
    localparam logic [7:0] GCP_EVENT_OFF = 8'h18;
    localparam logic [7:0] GCP_EVMASK_OFF = 8'h1c;
    localparam logic [7:0] GCP_CMD_OFF = 8'h20;

    // command word layout
    localparam int GCP_EOL_BIT = 0;
    localparam int GCP_OPC_LSB = 8;
    localparam logic [7:0] GCP_OPC_LINK = 8'h02;
    localparam logic [7:0] GCP_OPC_NOP = 8'h00;
    localparam logic [7:0] GCP_OPC_MAX = 8'h3f;

    // status layout: poll, illegal opcode, then six exception bits
    localparam int GCP_ST_POLL = 0;
    localparam int GCP_ST_ILL = 1;
    localparam int GCP_ST_EXC_LSB = 2;
    localparam int GCP_ST_W = 8;
    localparam int GCP_EXC_W = 6;
    localparam int GCP_IPTR_W = 22;

    localparam logic [15:0] GCP_OPCODE_RST = 16'h0001;
    localparam logic [7:0] GCP_STATUS_RST = 8'h01;
    localparam logic [7:0] GCP_IMASK_RST = 8'hff;
    localparam logic [5:0] GCP_PMASK_RST = 6'h3f;

    // event bits
    localparam int GCP_EV_POLL = 0;
    localparam int GCP_EV_START = 1;
    localparam int GCP_EV_W = 2;

    // cycles a command takes to execute in this control model
    localparam int GCP_EXEC_NS = 400;
    localparam int GCP_CLK_NS = 100;
    localparam logic [3:0] GCP_EXEC_CYC = 4'((GCP_EXEC_NS + GCP_CLK_NS - 1) / GCP_CLK_NS);

    typedef enum logic [2:0] {
        GCP_POLL = 3'b001,
        GCP_EXEC = 3'b010,
        GCP_FETCH = 3'b100
    } gcp_state_e;

endpackage

// [core/gcp_irq.sv]
// gcp_irq: sticky event flags, write-one-to-clear, mask and one level interrupt
// assumes event pulses and bus strobes on the same clock
module gcp_irq
    import gcp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // events and software access
    input wire logic [GCP_EV_W-1:0] event_i,
    input wire logic clear_we_i,
    input wire logic mask_we_i,
    input wire logic [GCP_EV_W-1:0] wdata_i,
    // state
    output logic [GCP_EV_W-1:0] flags_o,
    output logic [GCP_EV_W-1:0] mask_o,
    output logic irq_o
);
    logic [GCP_EV_W-1:0] flags_reg;
    logic [GCP_EV_W-1:0] flags_next;
    logic [GCP_EV_W-1:0] mask_reg;
    logic [GCP_EV_W-1:0] mask_next;

    always_comb
    begin
        // a new event wins over a clear in the same cycle
        flags_next = flags_reg;
        if (clear_we_i)
        begin
            flags_next = flags_reg & ~wdata_i;
        end
        flags_next = flags_next | event_i;
        mask_next = mask_we_i ? wdata_i : mask_reg;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            flags_reg <= '0;
            mask_reg <= '0;
        end
        else
        begin
            flags_reg <= flags_next;
            mask_reg <= mask_next;
        end
    end

    assign flags_o = flags_reg;
    assign mask_o = mask_reg;
    assign irq_o = |(flags_reg & mask_reg);
endmodule // gcp_irq

// [core/gcp_ctrl.sv]
// gcp_ctrl: poll state, start/stop, software abort and reset setup of the command fetcher
// assumes an apb master on clk_sys_i and a command word source on the same clock
// Functional notes
// - reset halts execution and enters poll state
// - enter poll on list end, exception, abort, illegal
// - poll: no execution, report idle, watch flag
// - valid opcode with cleared flag starts engine
// - flag set on a word: skip, poll
// - nop with flag set halts the list
// - status or pointer write raises abort
// - abort finishes current command, then polls
// - reset sets the end-of-list flag
// - reset clears status except poll flag set
// - reset sets interrupt mask all ones
// - reset sets poll-on-exception mask all ones
// - reset clears pick mode
// - flag bit 0, opcode high byte, 7:1 zero
// - each poll entry sets end-of-list flag
// - restart clears status that caused poll
//
// Chosen here: the APB interface to the registers and the address map.
module gcp_ctrl
    import gcp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // exception sources, one-cycle pulses
    input wire logic [GCP_EXC_W-1:0] exception_i,
    // next fetched command word from the command block
    input wire logic cmd_valid_i,
    input wire logic [15:0] cmd_word_i,
    output logic cmd_ready_o,
    // engine state
    output logic busy_o,
    output logic idle_o,
    output logic exec_start_o,
    output logic [7:0] exec_opcode_o,
    output logic pick_mode_o,
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic opc_legal(input logic [15:0] w);
        // low bits 7:1 must be zero and opcode must be known
        return (w[7:1] == 7'h00) && (w[15:GCP_OPC_LSB] <= GCP_OPC_MAX);
    endfunction

    gcp_state_e state_reg;
    gcp_state_e state_next;
    logic [15:0] opcode_reg;
    logic [15:0] opcode_next;
    logic [GCP_ST_W-1:0] status_reg;
    logic [GCP_ST_W-1:0] status_next;
    logic [GCP_IPTR_W-1:0] iptr_reg;
    logic [GCP_IPTR_W-1:0] iptr_next;
    logic [GCP_ST_W-1:0] imask_reg;
    logic [GCP_ST_W-1:0] imask_next;
    logic [GCP_EXC_W-1:0] pmask_reg;
    logic [GCP_EXC_W-1:0] pmask_next;
    logic pick_reg;
    logic pick_next;
    logic abort_reg;
    logic abort_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [7:0] cur_opc_reg;
    logic [7:0] cur_opc_next;
    logic start_reg;
    logic start_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    logic wr;
    logic rd;
    logic wr_opcode;
    logic exc_poll;
    logic enter_poll;
    logic leave_poll;
    logic [GCP_EV_W-1:0] ev;
    logic [GCP_EV_W-1:0] ev_flags;
    logic [GCP_EV_W-1:0] ev_mask;
    logic ev_irq;

    ////////////////////////////////////////////////////////////////////////
    // apb: zero wait state, every access answered in its access phase
    assign wr = psel_i && penable_i && pwrite_i;
    assign rd = psel_i && penable_i && !pwrite_i;
    assign pready_o = 1'b1;
    assign pslverr_o = 1'b0;
    assign wr_opcode = wr && (paddr_i == GCP_OPCODE_OFF);

    // an exception forces poll only where its poll mask bit is zero
    assign exc_poll = |(status_reg[GCP_ST_EXC_LSB +: GCP_EXC_W] & ~pmask_reg);

    always_comb
    begin
        state_next = state_reg;
        opcode_next = opcode_reg;
        status_next = status_reg;
        iptr_next = iptr_reg;
        imask_next = imask_reg;
        pmask_next = pmask_reg;
        pick_next = pick_reg;
        abort_next = abort_reg;
        cnt_next = cnt_reg;
        cur_opc_next = cur_opc_reg;
        start_next = 1'b0;
        enter_poll = 1'b0;
        leave_poll = 1'b0;

        // exceptions latch into status
        status_next[GCP_ST_EXC_LSB +: GCP_EXC_W] =
            status_reg[GCP_ST_EXC_LSB +: GCP_EXC_W] | exception_i;

        // register writes
        if (wr)
        begin
            unique case (paddr_i)
                GCP_OPCODE_OFF: opcode_next = pwdata_i[15:0];
                GCP_STATUS_OFF: status_next = pwdata_i[GCP_ST_W-1:0];
                GCP_IPTR_OFF: iptr_next = pwdata_i[GCP_IPTR_W-1:0];
                GCP_IMASK_OFF: imask_next = pwdata_i[GCP_ST_W-1:0];
                GCP_PMASK_OFF: pmask_next = pwdata_i[GCP_EXC_W-1:0];
                GCP_CTRL_OFF: pick_next = pwdata_i[0];
                default: ;
            endcase
        end
        // an exception in the cycle of a status write must not be lost
        status_next[GCP_ST_EXC_LSB +: GCP_EXC_W] =
            status_next[GCP_ST_EXC_LSB +: GCP_EXC_W] | exception_i;
        // a write to status or pointer aborts, ignored when idle
        if (wr && (paddr_i == GCP_STATUS_OFF || paddr_i == GCP_IPTR_OFF)
            && state_reg != GCP_POLL)
        begin
            abort_next = 1'b1;
        end

        unique case (state_reg)
            GCP_POLL:
            begin
                // continuous watch of the flag; start needs a legal word
                if (wr_opcode && !pwdata_i[GCP_EOL_BIT] && opc_legal(pwdata_i[15:0]))
                begin
                    leave_poll = 1'b1;
                    cur_opc_next = pwdata_i[15:GCP_OPC_LSB];
                    start_next = 1'b1;
                    cnt_next = GCP_EXEC_CYC;
                    state_next = GCP_EXEC;
                    // clear the causes of the poll state
                    status_next = '0;
                    status_next[GCP_ST_EXC_LSB +: GCP_EXC_W] = exception_i;
                end
                else if (wr_opcode && !pwdata_i[GCP_EOL_BIT])
                begin
                    status_next[GCP_ST_ILL] = 1'b1;
                    enter_poll = 1'b1;
                end
            end
            GCP_EXEC:
            begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1)
                begin
                    // command done; an abort stops here before the next one
                    if (abort_reg || exc_poll || status_reg[GCP_ST_ILL])
                    begin
                        enter_poll = 1'b1;
                    end
                    else
                    begin
                        state_next = GCP_FETCH;
                    end
                end
            end
            GCP_FETCH:
            begin
                if (abort_reg || exc_poll || status_reg[GCP_ST_ILL])
                begin
                    enter_poll = 1'b1;
                end
                else if (cmd_valid_i)
                begin
                    if (cmd_word_i[GCP_EOL_BIT])
                    begin
                        enter_poll = 1'b1;
                    end
                    else if (!opc_legal(cmd_word_i))
                    begin
                        status_next[GCP_ST_ILL] = 1'b1;
                        enter_poll = 1'b1;
                    end
                    else
                    begin
                        cur_opc_next = cmd_word_i[15:GCP_OPC_LSB];
                        start_next = 1'b1;
                        cnt_next = GCP_EXEC_CYC;
                        state_next = GCP_EXEC;
                    end
                end
            end
            default: enter_poll = 1'b1;
        endcase

        if (enter_poll)
        begin
            state_next = GCP_POLL;
            abort_next = 1'b0;
            opcode_next[GCP_EOL_BIT] = 1'b1;
            status_next[GCP_ST_POLL] = 1'b1;
        end
        if (leave_poll)
        begin
            abort_next = 1'b0;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        rdata_next = rdata_reg;
        if (psel_i && !penable_i && !pwrite_i)
        begin
            unique case (paddr_i)
                GCP_OPCODE_OFF: rdata_next = {16'h0000, opcode_reg};
                GCP_STATUS_OFF: rdata_next = {24'h000000, status_reg};
                GCP_IPTR_OFF: rdata_next = {10'h000, iptr_reg};
                GCP_IMASK_OFF: rdata_next = {24'h000000, imask_reg};
                GCP_PMASK_OFF: rdata_next = {26'h0000000, pmask_reg};
                GCP_CTRL_OFF: rdata_next = {31'h00000000, pick_reg};
                GCP_EVENT_OFF: rdata_next = {30'h00000000, ev_flags};
                GCP_EVMASK_OFF: rdata_next = {30'h00000000, ev_mask};
                GCP_CMD_OFF: rdata_next = {24'h000000, cur_opc_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= GCP_POLL;
            opcode_reg <= GCP_OPCODE_RST;
            status_reg <= GCP_STATUS_RST;
            iptr_reg <= '0;
            imask_reg <= GCP_IMASK_RST;
            pmask_reg <= GCP_PMASK_RST;
            pick_reg <= 1'b0;
            abort_reg <= 1'b0;
            cnt_reg <= 4'h0;
            cur_opc_reg <= 8'h00;
            start_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            state_reg <= state_next;
            opcode_reg <= opcode_next;
            status_reg <= status_next;
            iptr_reg <= iptr_next;
            imask_reg <= imask_next;
            pmask_reg <= pmask_next;
            pick_reg <= pick_next;
            abort_reg <= abort_next;
            cnt_reg <= cnt_next;
            cur_opc_reg <= cur_opc_next;
            start_reg <= start_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt: poll entry and start events
    assign ev[GCP_EV_POLL] = enter_poll && state_reg != GCP_POLL;
    assign ev[GCP_EV_START] = leave_poll;

    gcp_irq u_irq
    (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .event_i(ev),
        .clear_we_i(wr && paddr_i == GCP_EVENT_OFF),
        .mask_we_i(wr && paddr_i == GCP_EVMASK_OFF),
        .wdata_i(pwdata_i[GCP_EV_W-1:0]),
        .flags_o(ev_flags),
        .mask_o(ev_mask),
        .irq_o(ev_irq)
    );

    assign prdata_o = rdata_reg;
    assign cmd_ready_o = (state_reg == GCP_FETCH) && !abort_reg;
    assign busy_o = state_reg != GCP_POLL;
    assign idle_o = state_reg == GCP_POLL;
    assign exec_start_o = start_reg;
    assign exec_opcode_o = cur_opc_reg;
    assign pick_mode_o = pick_reg;
    assign irq_o = ev_irq;
endmodule // gcp_ctrl

// [test/gcp_ctrl_checker.sv]
// gcp_ctrl_checker: timing checks on the poll control ports
// assumes binding to gcp_ctrl, one clock, active-low async reset
module gcp_ctrl_checker
    import gcp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    // command source and state
    input wire logic cmd_valid_i,
    input wire logic [15:0] cmd_word_i,
    input wire logic cmd_ready_o,
    input wire logic busy_o,
    input wire logic idle_o,
    input wire logic exec_start_o,
    input wire logic [7:0] exec_opcode_o,
    input wire logic pick_mode_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    logic wr_acc;
    logic abort_wr;
    logic link_wr;
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign abort_wr = wr_acc && (paddr_i == GCP_STATUS_OFF || paddr_i == GCP_IPTR_OFF);
    assign link_wr = wr_acc && paddr_i == GCP_OPCODE_OFF && pwdata_i[15:0] == 16'h0200;

    a_idle_not_busy: assert property (idle_o == !busy_o)
        else $error("idle and busy disagree");
    a_no_run_idle: assert property (idle_o |-> !exec_start_o && !cmd_ready_o)
        else $error("work started while idle");
    a_link_start: assert property (idle_o && link_wr |=> busy_o && exec_start_o && exec_opcode_o == 8'h02)
        else $error("link write did not start");
    a_fetch_eol: assert property (cmd_valid_i && cmd_ready_o && cmd_word_i[0] |=> idle_o && !exec_start_o)
        else $error("end word did not stop");
    a_exec_len: assert property ($rose(busy_o) |-> !cmd_ready_o [*4] ##1 (cmd_ready_o || idle_o))
        else $error("command length wrong");
    a_abort_stop: assert property (busy_o && abort_wr |=> !exec_start_o throughout ##[0:3] idle_o)
        else $error("abort did not stop");
    a_abort_idle: assert property (idle_o && abort_wr |=> idle_o [*2])
        else $error("abort left poll");
    a_reset_state: assert property ($rose(nrst_i) |-> idle_o && !pick_mode_o && !exec_start_o)
        else $error("reset state wrong");

    c_start: cover property (exec_start_o && busy_o);
    c_end_word: cover property (cmd_valid_i && cmd_ready_o && cmd_word_i[0]);
    c_abort: cover property (busy_o && abort_wr);
endmodule // gcp_ctrl_checker

bind gcp_ctrl gcp_ctrl_checker u_chk (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .cmd_valid_i(cmd_valid_i),
    .cmd_word_i(cmd_word_i), .cmd_ready_o(cmd_ready_o), .busy_o(busy_o), .idle_o(idle_o),
    .exec_start_o(exec_start_o), .exec_opcode_o(exec_opcode_o), .pick_mode_o(pick_mode_o)
);

// [test/gcp_cmd_src.sv]
// gcp_cmd_src: command block memory model feeding words to the fetcher
// assumes a word is taken on a rising edge with valid and ready high
module gcp_cmd_src
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // command word handshake
    input wire logic cmd_ready_i,
    output logic cmd_valid_o,
    output logic [15:0] cmd_word_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // bit 0 ends the list, opcode in high byte, bits 7:1 zero
    logic [15:0] words [$];
    int gap = 0;
    int wait_cnt = 0;
    logic take;

    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_word_o = 16'h5a5a;
    end

    // idle data toggles so a stale word never looks valid
    always @(posedge clk_sys_i)
    begin
        take = cmd_valid_o && cmd_ready_i && words.size() > 0;
        if (take)
        begin
            void'(words.pop_front());
            wait_cnt = gap;
        end
        else if (wait_cnt > 0)
            wait_cnt = wait_cnt - 1;
        take = nrst_i && !take && wait_cnt == 0 && words.size() > 0;
        cmd_valid_o <= take;
        cmd_word_o <= take ? words[0] : ~cmd_word_o;
    end
endmodule // gcp_cmd_src

// [test/gcp_ctrl_test.sv]
// gcp_ctrl_test: directed scenarios for the poll control block
// assumes gcp_ctrl with the bound checker and the gcp_cmd_src model
module gcp_ctrl_test
    import gcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [GCP_EXC_W-1:0] exc = '0;
    logic [31:0] prdata;
    logic [15:0] cmd_word;
    logic [7:0] exec_opc;
    logic pready, pslverr, cmd_valid, cmd_ready, busy, idle, exec_start, pick, irq;
    int err_count = 0;
    int num_checks = 0;
    int n_start = 0;

    always #50 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (exec_start === 1'b1) n_start <= n_start + 1;

    gcp_ctrl u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .exception_i(exc), .cmd_valid_i(cmd_valid),
        .cmd_word_i(cmd_word), .cmd_ready_o(cmd_ready), .busy_o(busy), .idle_o(idle),
        .exec_start_o(exec_start), .exec_opcode_o(exec_opc), .pick_mode_o(pick), .irq_o(irq));
    gcp_cmd_src u_src (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_ready_i(cmd_ready),
        .cmd_valid_o(cmd_valid), .cmd_word_o(cmd_word));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one extra edge after release so back-to-back calls never double-drive psel
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        apb(1'b0, a, 32'h0, q);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 200 && idle !== 1'b1; i++) @(posedge clk_sys_i);
        chk(idle, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] adr [5] = '{GCP_OPCODE_OFF, GCP_STATUS_OFF, GCP_IMASK_OFF, GCP_PMASK_OFF,
            GCP_CTRL_OFF};
        logic [31:0] exp [5] = '{32'h1, 32'h1, 32'hff, 32'h3f, 32'h0};
        logic [31:0] q;
        chk(idle, 1);
        for (int i = 0; i < 5; i++)
        begin
            rd(adr[i], q);
            chk(q, exp[i]);
        end
    endtask

    task automatic t_list();
        logic [31:0] q;
        u_src.gap = 2;
        u_src.words = '{16'h0500, 16'h0001};
        n_start = 0;
        wr(GCP_OPCODE_OFF, 32'h0200);
        chk(busy, 1);
        chk(exec_opc, 8'h02);
        wait_idle();
        chk(n_start, 2);
        rd(GCP_OPCODE_OFF, q);
        chk(q, 32'h0201);
        rd(GCP_CMD_OFF, q);
        chk(q, 32'h5);
        rd(GCP_STATUS_OFF, q);
        chk(q[0], 1);
        u_src.gap = 0;
    endtask

    task automatic t_no_start();
        logic [31:0] q;
        n_start = 0;
        wr(GCP_OPCODE_OFF, 32'h0201);
        chk(idle, 1);
        chk(n_start, 0);
        u_src.words = '{16'h0502};
        wr(GCP_OPCODE_OFF, 32'h4000);
        rd(GCP_STATUS_OFF, q);
        chk(q[1], 1);
        chk(idle, 1);
        wr(GCP_OPCODE_OFF, 32'h0200);
        rd(GCP_STATUS_OFF, q);
        chk(q, 32'h0);
        wait_idle();
        rd(GCP_STATUS_OFF, q);
        chk(q[1], 1);
    endtask

    task automatic t_abort();
        logic [7:0] adr [2] = '{GCP_STATUS_OFF, GCP_IPTR_OFF};
        logic [31:0] q;
        for (int i = 0; i < 2; i++)
        begin
            u_src.words = '{16'h0500, 16'h0001};
            n_start = 0;
            wr(GCP_OPCODE_OFF, 32'h0200);
            wr(adr[i], 32'h0);
            wait_idle();
            chk(n_start, 1);
            u_src.words.delete();
        end
        n_start = 0;
        wr(GCP_IPTR_OFF, 32'h123);
        wr(GCP_STATUS_OFF, 32'h0);
        chk(idle, 1);
        chk(n_start, 0);
        rd(GCP_IPTR_OFF, q);
        chk(q, 32'h123);
    endtask

    task automatic t_exception();
        logic [31:0] q;
        wr(GCP_PMASK_OFF, 32'h3e);
        u_src.words = '{16'h0500, 16'h0500, 16'h0001};
        n_start = 0;
        wr(GCP_OPCODE_OFF, 32'h0200);
        exc <= 6'h01;
        @(posedge clk_sys_i);
        exc <= 6'h00;
        wait_idle();
        chk(n_start, 1);
        rd(GCP_STATUS_OFF, q);
        chk(q[2], 1);
        u_src.words.delete();
        wr(GCP_PMASK_OFF, 32'h3f);
    endtask

    task automatic t_irq();
        logic [31:0] q;
        wr(GCP_EVENT_OFF, 32'h3);
        wr(GCP_EVMASK_OFF, 32'h1);
        chk(irq, 0);
        u_src.words = '{16'h0001};
        wr(GCP_OPCODE_OFF, 32'h0200);
        wait_idle();
        @(posedge clk_sys_i);
        chk(irq, 1);
        wr(GCP_EVMASK_OFF, 32'h0);
        chk(irq, 0);
        wr(GCP_EVMASK_OFF, 32'h1);
        chk(irq, 1);
        wr(GCP_EVENT_OFF, 32'h1);
        chk(irq, 0);
        rd(8'h3c, q);
        chk(q, 32'h0);
        chk(pslverr, 0);
    endtask

    task automatic t_pick_reset();
        logic [31:0] q;
        wr(GCP_CTRL_OFF, 32'h1);
        chk(pick, 1);
        u_src.words = '{16'h0500, 16'h0001};
        wr(GCP_OPCODE_OFF, 32'h0200);
        chk(busy, 1);
        nrst_i <= 1'b0;
        u_src.words.delete();
        @(posedge clk_sys_i);
        chk(idle, 1);
        chk(pick, 0);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(GCP_OPCODE_OFF, q);
        chk(q, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        t_reset();
        t_list();
        t_no_start();
        t_abort();
        t_exception();
        t_irq();
        t_pick_reset();
        results();
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        results();
    end
endmodule // gcp_ctrl_test
